/* File: rtl/tsw_pkg.sv */
package tsw_pkg;
  localparam int RST_MIN_NS = 100;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int RST_MIN_CYC = (RST_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [1:0] RGN_DM = 2'h3;
  localparam logic [1:0] RGN_CM = 2'h2;
  localparam logic [1:0] RGN_REG = 2'h1;
  localparam logic [2:0] RSEL_CTRL = 3'h0;
  localparam logic [2:0] RSEL_STAT = 3'h1;
  localparam logic [2:0] RSEL_OFF0 = 3'h2;
  localparam logic [2:0] RSEL_OFF3 = 3'h5;
  localparam int CTRL_STBY_BIT = 4;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [1:0] FN_PROC = 2'h2;
  localparam logic [1:0] FN_HIZ = 2'h3;
  localparam logic [1:0] RATE_16M = 2'h3;
  localparam logic [3:0] OFF_MAX_LOW = 4'h9;
  localparam logic [3:0] OFF_MAX_16M = 4'h5;
  localparam logic [1:0] STAB_IDLE = 2'h3;
  localparam int DLY_TAPS = 10;
  localparam int WQ_DEPTH = 2;
  typedef struct packed {
    logic rsv;
    logic [1:0] func;
    logic loopback;
    logic [3:0] src_lane;
    logic [7:0] src_chan;
  } tsw_cm_word_t;
  typedef struct packed {
    logic [13:0] addr;
    logic [15:0] data;
  } tsw_wreq_t;
  typedef struct packed {
    logic [7:0] chan;
    logic [2:0] bitn;
    logic [2:0] k;
  } tsw_slot_t;
  typedef struct packed {
    logic cs_n;
    logic strobe_n;
    logic rw;
    logic [13:0] addr;
    logic [15:0] data;
  } tsw_host_pins_t;
  localparam tsw_host_pins_t HOST_PINS_RST = 33'h1_8000_0000;
  typedef enum logic [2:0] {HP_IDLE = 3'h1, HP_ACK = 3'h2, HP_REL = 3'h4} tsw_hp_state_t;
endpackage

/* File: rtl/tsw_switch.sv */
`timescale 1ns/1ps
`default_nettype none
module tsw_switch #(
  parameter int LANES = 16,
  parameter int DEPTH = tsw_pkg::WQ_DEPTH
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic serial_clk_in,
  input wire logic frame_sync_in,
  input wire logic wide_sync_select_in,
  input wire logic serial_drive_pin_in,
  input wire logic [LANES-1:0] serial_in_lanes_in,
  output logic [LANES-1:0] serial_out_lanes_out,
  output logic [LANES-1:0] serial_out_oe_out,
  output logic [LANES-1:0] lane_drive_indicator_out,
  input wire logic host_cs_n_in,
  input wire logic host_strobe_n_in,
  input wire logic host_rw_in,
  input wire logic [13:0] host_addr_bus_in,
  input wire logic [15:0] host_data_bus_in,
  output logic [15:0] host_data_bus_out,
  output logic host_data_bus_oe_out,
  output logic transfer_ack_n_out,
  output logic transfer_ack_n_oe_out
);
  import tsw_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (LANES < 1 || LANES > 16 || DEPTH < 2)
    begin : g_bad_cfg
      $error("tsw_switch: LANES must be 1..16 and DEPTH at least 2");
    end
  endgenerate

  function automatic logic [3:0] f_cpb(input logic [1:0] rate, input logic [1:0] maxr);
    f_cpb = (maxr == RATE_16M) ? 4'(4'h1 << (maxr - rate)) : 4'(4'h2 << (maxr - rate));
  endfunction

  function automatic tsw_slot_t f_step(input tsw_slot_t s, input logic [3:0] cpb,
                                       input logic [1:0] rate);
    logic [7:0] last;
    f_step = s;
    last = 8'((9'h020 << rate) - 9'h001);
    if ({1'b0, s.k} != cpb - 4'h1)
      f_step.k = s.k + 3'h1;
    else
    begin
      f_step.k = 3'h0;
      f_step.bitn = s.bitn + 3'h1;
      if (s.bitn == 3'h7)
        f_step.chan = (s.chan == last) ? 8'h00 : s.chan + 8'h01;
    end
  endfunction

  logic [7:0] dm_mem [4096];
  logic [15:0] cm_mem [4096];
  tsw_wreq_t wq_mem [DEPTH];

  logic [2:0] sclk_ff;
  logic [2:0] fs_ff;
  logic [1:0] wide_ff;
  logic [1:0] drive_ff;
  logic [LANES-1:0] rx_s1_ff;
  logic [LANES-1:0] rx_s2_ff;
  tsw_host_pins_t hp_s1_ff;
  tsw_host_pins_t hs_ff;
  logic [1:0] stab_ff;
  logic gci_ff;
  logic frame_ok_ff;
  logic pulse_ff;
  logic [15:0] ctrl_ff;
  logic [3:0] off_ff [LANES];
  logic [DLY_TAPS-1:0] dly_ff [LANES];
  logic [7:0] sh_in_ff [LANES];
  logic [7:0] sh_out_ff [LANES];
  logic [LANES-1:0] chan_en_ff;
  logic [LANES-1:0] tx_ff;
  logic [LANES-1:0] oe_ff;
  tsw_slot_t in_cur_ff;
  tsw_slot_t out_cur_ff;
  logic [PW-1:0] wq_wr_ff;
  logic [PW-1:0] wq_rd_ff;
  logic [PW:0] wq_cnt_ff;
  tsw_hp_state_t hp_state_ff;
  logic [15:0] hdata_ff;
  logic hdata_oe_ff;
  logic ack_n_ff;
  logic ack_oe_ff;

  // serial clock edges and format-dependent edge roles
  wire sclk_rise = sclk_ff[1] & ~sclk_ff[2];
  wire sclk_fall = ~sclk_ff[1] & sclk_ff[2];
  wire sedge = sclk_rise | sclk_fall;
  wire gci_eff = gci_ff & ~wide_ff[1];
  wire launch = gci_eff ? sclk_rise : sclk_fall;
  wire sample = gci_eff ? sclk_fall : sclk_rise;
  wire fs_now = fs_ff[1];
  wire fs_prev = fs_ff[2];
  wire fs_change = fs_now != fs_prev;
  wire sync_act = gci_eff ? fs_now : ~fs_now;
  // wide pulse aligns on falling edge
  wire pulse_set = wide_ff[1] ? (fs_prev & ~fs_now) : (sample & sync_act);
  wire frame_start = launch & pulse_ff;

  wire [3:0] rate_code = ctrl_ff[3:0];
  wire mux_mode = rate_code[3:2] != 2'h0;
  wire [1:0] out_rate = rate_code[1:0];
  wire [1:0] in_rate = mux_mode ? 2'(rate_code[3:2] - 2'h1) : rate_code[1:0];
  wire [1:0] max_rate = (in_rate > out_rate) ? in_rate : out_rate;
  wire [3:0] in_cpb = f_cpb(in_rate, max_rate);
  wire [3:0] out_cpb = f_cpb(out_rate, max_rate);
  wire tsw_slot_t in_nxt = frame_start ? '0 : f_step(in_cur_ff, in_cpb, in_rate);
  wire tsw_slot_t out_nxt = frame_start ? '0 : f_step(out_cur_ff, out_cpb, out_rate);
  wire in_smp = sample & (in_cur_ff.k == 3'(in_cpb - 4'h1));
  wire in_last_bit = in_smp & (in_cur_ff.bitn == 3'h7);
  wire out_shift = launch & (out_nxt.k == 3'h0);
  wire out_load = out_shift & (out_nxt.bitn == 3'h0);
  wire glob_en = drive_ff[1] | ctrl_ff[CTRL_STBY_BIT];
  wire [3:0] off_max = (in_rate == RATE_16M) ? OFF_MAX_16M : OFF_MAX_LOW;

  wire [LANES-1:0] tap;
  wire [7:0] out_byte [LANES];
  wire [LANES-1:0] out_en;
  wire [63:0] off_flat;
  genvar g;
  generate
    for (g = 0; g < 16; g++)
    begin : g_lane
      if (g < LANES)
      begin : g_on
        wire [3:0] off_eff = (off_ff[g] > off_max) ? off_max : off_ff[g];
        assign tap[g] = (off_eff == 4'h0) ? rx_s2_ff[g] : dly_ff[g][off_eff - 4'h1];
        wire tsw_cm_word_t cmw = cm_mem[{4'(g), out_nxt.chan}];
        wire [7:0] src_byte = dm_mem[{cmw.src_lane, cmw.src_chan}];
        assign out_byte[g] = (cmw.func == FN_PROC) ? cmw.src_chan : src_byte;
        assign out_en[g] = cmw.func != FN_HIZ;
        assign off_flat[g*4 +: 4] = off_ff[g];
      end
      else
      begin : g_off
        assign off_flat[g*4 +: 4] = 4'h0;
      end
    end
  endgenerate

  wire host_act = ~hs_ff.cs_n & ~hs_ff.strobe_n;
  wire [1:0] rgn = hs_ff.addr[13:12];
  wire [2:0] rsel = hs_ff.addr[11:9];
  wire [11:0] maddr = hs_ff.addr[11:0];
  wire off_sel = (rsel >= RSEL_OFF0) && (rsel <= RSEL_OFF3);
  wire [1:0] off_grp = 2'(rsel - RSEL_OFF0);
  wire [15:0] stat_word = {2'h0, frame_ok_ff, gci_eff, 12'h000};
  wire [15:0] reg_word = (rsel == RSEL_CTRL) ? ctrl_ff :
                         (rsel == RSEL_STAT) ? stat_word :
                         off_sel ? off_flat[off_grp*16 +: 16] : 16'h0000;
  wire [15:0] rd_word = (rgn == RGN_DM) ? {8'h00, dm_mem[maddr]} :
                        (rgn == RGN_CM) ? cm_mem[maddr] :
                        (rgn == RGN_REG) ? reg_word : 16'h0000;

  wire wq_in_valid = (hp_state_ff == HP_IDLE) & host_act & ~hs_ff.rw;
  wire wq_in_ready = wq_cnt_ff != (PW + 1)'(DEPTH);
  wire wq_push = wq_in_valid & wq_in_ready;
  wire wq_out_valid = wq_cnt_ff != '0;
  // queue drains only when the output path is not loading
  wire wq_out_ready = ~out_load;
  wire wq_pop = wq_out_valid & wq_out_ready;
  wire tsw_wreq_t wq_head = wq_mem[wq_rd_ff];
  wire [1:0] w_rgn = wq_head.addr[13:12];
  wire [2:0] w_rsel = wq_head.addr[11:9];
  wire [PW-1:0] wq_wr_inc = (wq_wr_ff == PW'(DEPTH - 1)) ? '0 : wq_wr_ff + 1'b1;
  wire [PW-1:0] wq_rd_inc = (wq_rd_ff == PW'(DEPTH - 1)) ? '0 : wq_rd_ff + 1'b1;
  wire [PW:0] nxt_wq_cnt = wq_cnt_ff + (PW + 1)'(wq_push) - (PW + 1)'(wq_pop);

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sclk_ff <= 3'h0;
      fs_ff <= 3'h7;
      wide_ff <= 2'h0;
      drive_ff <= 2'h0;
      rx_s1_ff <= '0;
      rx_s2_ff <= '0;
      hp_s1_ff <= HOST_PINS_RST;
      hs_ff <= HOST_PINS_RST;
      in_cur_ff <= '0;
      out_cur_ff <= '0;
      pulse_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      sclk_ff <= {sclk_ff[1:0], serial_clk_in};
      fs_ff <= {fs_ff[1:0], frame_sync_in};
      wide_ff <= {wide_ff[0], wide_sync_select_in};
      drive_ff <= {drive_ff[0], serial_drive_pin_in};
      rx_s1_ff <= serial_in_lanes_in;
      rx_s2_ff <= rx_s1_ff;
      hp_s1_ff <= {host_cs_n_in, host_strobe_n_in, host_rw_in, host_addr_bus_in,
                   host_data_bus_in};
      hs_ff <= hp_s1_ff;
      pulse_ff <= pulse_set | (pulse_ff & ~launch);
      if (launch)
      begin
        in_cur_ff <= in_nxt;
        out_cur_ff <= out_nxt;
      end
    end
  end

  // idle level of sync gives format
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      stab_ff <= 2'h0;
      gci_ff <= 1'b0;
      frame_ok_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      if (fs_change)
      begin
        stab_ff <= 2'h0;
        if (stab_ff == STAB_IDLE)
        begin
          gci_ff <= ~fs_prev;
          frame_ok_ff <= 1'b1;
        end
      end
      else if (sedge && stab_ff != STAB_IDLE)
        stab_ff <= stab_ff + 2'h1;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      for (int l = 0; l < LANES; l++)
      begin
        dly_ff[l] <= '0;
        sh_in_ff[l] <= 8'h00;
        sh_out_ff[l] <= 8'h00;
      end
      chan_en_ff <= '0;
      tx_ff <= '0;
      oe_ff <= '0;
    end
    else if (ce_in)
    begin
      for (int l = 0; l < LANES; l++)
      begin
        if (sedge)
          dly_ff[l] <= {dly_ff[l][DLY_TAPS-2:0], rx_s2_ff[l]};
        if (in_smp)
          sh_in_ff[l] <= {sh_in_ff[l][6:0], tap[l]};
        if (out_load)
        begin
          tx_ff[l] <= out_byte[l][7];
          sh_out_ff[l] <= {out_byte[l][6:0], 1'b0};
          chan_en_ff[l] <= out_en[l];
        end
        else if (out_shift)
        begin
          tx_ff[l] <= sh_out_ff[l][7];
          sh_out_ff[l] <= {sh_out_ff[l][6:0], 1'b0};
        end
      end
      oe_ff <= (out_load ? out_en : chan_en_ff) & {LANES{glob_en}};
    end
  end

  // data memory written only from lanes
  always_ff @(posedge clock_in)
  begin
    if (ce_in)
    begin
      if (in_last_bit)
        for (int l = 0; l < LANES; l++)
          dm_mem[{4'(l), in_cur_ff.chan}] <= {sh_in_ff[l][6:0], tap[l]};
      if (wq_pop && w_rgn == RGN_CM)
        cm_mem[wq_head.addr[11:0]] <= wq_head.data;
      if (wq_push)
        wq_mem[wq_wr_ff] <= {hs_ff.addr, hs_ff.data};
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ctrl_ff <= CTRL_RST;
      for (int l = 0; l < LANES; l++)
        off_ff[l] <= 4'h0;
      wq_wr_ff <= '0;
      wq_rd_ff <= '0;
      wq_cnt_ff <= '0;
    end
    else if (ce_in)
    begin
      if (wq_push)
        wq_wr_ff <= wq_wr_inc;
      if (wq_pop)
        wq_rd_ff <= wq_rd_inc;
      wq_cnt_ff <= nxt_wq_cnt;
      if (wq_pop && w_rgn == RGN_REG)
      begin
        if (w_rsel == RSEL_CTRL)
          ctrl_ff <= wq_head.data;
        for (int l = 0; l < LANES; l++)
          if (w_rsel == 3'(RSEL_OFF0 + 3'(l / 4)))
            off_ff[l] <= wq_head.data[(l % 4) * 4 +: 4];
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      hp_state_ff <= HP_IDLE;
      hdata_ff <= 16'h0000;
      hdata_oe_ff <= 1'b0;
      ack_n_ff <= 1'b1;
      ack_oe_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      unique case (hp_state_ff)
        HP_IDLE:
          if (host_act && (hs_ff.rw || wq_in_ready))
          begin
            hdata_ff <= rd_word;
            hdata_oe_ff <= hs_ff.rw;
            ack_n_ff <= 1'b0;
            ack_oe_ff <= 1'b1;
            hp_state_ff <= HP_ACK;
          end
        HP_ACK:
          if (!host_act)
          begin
            ack_n_ff <= 1'b1;
            hdata_oe_ff <= 1'b0;
            hp_state_ff <= HP_REL;
          end
        HP_REL:
        begin
          ack_oe_ff <= 1'b0;
          hp_state_ff <= HP_IDLE;
        end
      endcase
    end
  end

  assign serial_out_lanes_out = tx_ff;
  assign serial_out_oe_out = oe_ff;
  assign lane_drive_indicator_out = oe_ff;
  assign host_data_bus_out = hdata_ff;
  assign host_data_bus_oe_out = hdata_oe_ff;
  assign transfer_ack_n_out = ack_n_ff;
  assign transfer_ack_n_oe_out = ack_oe_ff;
endmodule // tsw_switch
`default_nettype wire

/* File: test/tsw_switch_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module tsw_switch_monitor #(
  parameter int LANES = 16
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic host_cs_n_in,
  input wire logic host_strobe_n_in,
  input wire logic host_rw_in,
  input wire logic host_data_bus_oe_out,
  input wire logic transfer_ack_n_out,
  input wire logic transfer_ack_n_oe_out,
  input wire logic [LANES-1:0] serial_out_oe_out,
  input wire logic [LANES-1:0] lane_drive_indicator_out
);
  wire logic sel = !host_cs_n_in && !host_strobe_n_in;
  wire logic ack = !transfer_ack_n_out && transfer_ack_n_oe_out;
  default clocking cb @(posedge clock_in);
  endclocking
  a_reset_floats:
    assert property (!rst_n_in |-> !(|serial_out_oe_out) && !host_data_bus_oe_out
      && !transfer_ack_n_oe_out) else $error("outputs driven during reset");
  a_ack_needs_select:
    assert property (disable iff (!rst_n_in) $fell(transfer_ack_n_out)
      |-> $past(sel, 3) || $past(sel, 4)) else $error("ack without select");
  a_ack_stands_strobe:
    assert property (disable iff (!rst_n_in) ack |-> $past(sel, 3) || $past(sel, 4))
    else $error("ack held without strobe");
  a_read_ack_soon:
    assert property (disable iff (!rst_n_in) $rose(sel) && host_rw_in |-> ##[2:6] ack)
    else $error("read not acknowledged in time");
  a_ack_drive_release:
    assert property (disable iff (!rst_n_in) $rose(transfer_ack_n_out)
      |-> transfer_ack_n_oe_out ##1 !transfer_ack_n_oe_out) else $error("ack release wrong");
  a_ack_float_high:
    assert property (disable iff (!rst_n_in) $fell(transfer_ack_n_oe_out)
      |-> $past(transfer_ack_n_out)) else $error("ack floated while low");
  a_data_with_ack:
    assert property (disable iff (!rst_n_in) host_data_bus_oe_out |-> ack)
    else $error("data driven outside ack");
  a_data_read_only:
    assert property (disable iff (!rst_n_in) $rose(host_data_bus_oe_out)
      |-> $past(host_rw_in, 2) && $past(host_rw_in, 3)) else $error("data driven on write");
  a_indicator_match:
    assert property (disable iff (!rst_n_in) lane_drive_indicator_out == serial_out_oe_out)
    else $error("indicator differs from lane drive");
endmodule // tsw_switch_monitor
bind tsw_switch tsw_switch_monitor #(.LANES(LANES)) tsw_switch_monitor_i (
  .clock_in(clock_in),
  .rst_n_in(rst_n_in),
  .host_cs_n_in(host_cs_n_in),
  .host_strobe_n_in(host_strobe_n_in),
  .host_rw_in(host_rw_in),
  .host_data_bus_oe_out(host_data_bus_oe_out),
  .transfer_ack_n_out(transfer_ack_n_out),
  .transfer_ack_n_oe_out(transfer_ack_n_oe_out),
  .serial_out_oe_out(serial_out_oe_out),
  .lane_drive_indicator_out(lane_drive_indicator_out)
);
`default_nettype wire

/* File: test/tsw_serial_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module tsw_serial_peer (
  output logic sclk_out,
  output logic sync_n_out,
  output logic [15:0] rx_out
);
  int k = 0;
  int frames = 0;
  function automatic logic [7:0] rx_byte(input int ln, input int ch);
    return 8'((ln * 16 + ch) ^ 'h5a);
  endfunction
  // master clock at twice the lane rate
  initial
  begin
    sclk_out = 1'b0;
    sync_n_out = 1'b1;
    rx_out = '0;
    forever #40 sclk_out = ~sclk_out;
  end
  // low sync before frame, msb first, bits on every second falling edge
  always @(negedge sclk_out)
  begin
    logic [7:0] b;
    k = (k + 1) % 512;
    if (k == 0)
      frames = frames + 1;
    sync_n_out = (k != 511);
    for (int l = 0; l < 16; l++)
    begin
      b = rx_byte(l, k / 16);
      rx_out[l] = b[7 - (k / 2) % 8];
    end
  end
endmodule // tsw_serial_peer
`default_nettype wire

/* File: test/tb_tsw_switch.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_tsw_switch;
  import tsw_pkg::*;
  logic clock_in, rst_n_in, sclk, sync_n, pin, wide, cs_n, stb_n, rw, hoe, ack_n, ack_oe, o, di;
  logic [13:0] addr;
  logic [15:0] wdat, rd, hdo, rx, tx, oe, ind;
  logic [7:0] b;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  localparam logic [13:0] CTRL_A = {RGN_REG, RSEL_CTRL, 9'h000};
  localparam logic [13:0] STAT_A = {RGN_REG, RSEL_STAT, 9'h000};
  localparam logic [13:0] OFF_A = {RGN_REG, RSEL_OFF0, 9'h000};
  tsw_serial_peer tsw_serial_peer_i (.sclk_out(sclk), .sync_n_out(sync_n), .rx_out(rx));
  tsw_switch tsw_switch_i (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .ce_in(1'b1), .serial_clk_in(sclk),
    .frame_sync_in(sync_n), .wide_sync_select_in(wide), .serial_drive_pin_in(pin),
    .serial_in_lanes_in(rx), .serial_out_lanes_out(tx), .serial_out_oe_out(oe),
    .lane_drive_indicator_out(ind), .host_cs_n_in(cs_n), .host_strobe_n_in(stb_n),
    .host_rw_in(rw), .host_addr_bus_in(addr), .host_data_bus_in(wdat),
    .host_data_bus_out(hdo), .host_data_bus_oe_out(hoe), .transfer_ack_n_out(ack_n),
    .transfer_ack_n_oe_out(ack_oe)
  );
  initial
  begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic hacc(input logic r, input logic [13:0] a, input logic [15:0] d);
    int n = 0;
    @(negedge clock_in);
    cs_n = 1'b0;
    stb_n = 1'b0;
    rw = r;
    addr = a;
    wdat = d;
    while (!(ack_oe === 1'b1 && ack_n === 1'b0) && n < 40)
    begin
      @(negedge clock_in);
      n++;
    end
    chk("host ack wait", 16'h0, 16'(n == 40));
    rd = hdo;
    cs_n = 1'b1;
    stb_n = 1'b1;
    repeat (8) @(negedge clock_in);
  endtask
  task automatic rdc(input string nm, input logic [13:0] a, input logic [15:0] e,
                     input logic [15:0] m);
    hacc(1'b1, a, 16'h0000);
    chk(nm, e, rd & m);
  endtask
  function automatic logic [13:0] cm(input logic [3:0] l, input logic [7:0] c);
    return {RGN_CM, l, c};
  endfunction
  function automatic logic [13:0] dm(input logic [3:0] l, input logic [7:0] c);
    return {RGN_DM, l, c};
  endfunction
  task automatic grab(input int ln, input int ch);
    @(posedge sclk);
    while (tsw_serial_peer_i.k != ch * 16 + 1)
      @(posedge sclk);
    o = oe[ln];
    di = ind[ln];
    for (int i = 7; i >= 0; i--)
    begin
      b[i] = tx[ln];
      if (i > 0)
        repeat (2) @(posedge sclk);
    end
  endtask
  always @(posedge clock_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 70000)
    begin
      err_count++;
      conclude();
    end
  end
  initial
  begin
    rst_n_in = 1'b0;
    pin = 1'b0;
    wide = 1'b0;
    cs_n = 1'b1;
    stb_n = 1'b1;
    rw = 1'b1;
    addr = '0;
    wdat = '0;
    repeat (RST_MIN_CYC) @(negedge clock_in);
    chk("reset outputs", 16'h0, oe | ind | {13'h0, hoe, ack_oe, ~ack_n});
    rst_n_in = 1'b1;
    repeat (4) @(negedge clock_in);
    hacc(1'b0, CTRL_A, 16'h0f00);
    rdc("control", CTRL_A, 16'h0f00, 16'hffff);
    hacc(1'b0, 14'h0abc, 16'h1234);
    rdc("region zero", 14'h0abc, 16'h0000, 16'hffff);
    hacc(1'b0, OFF_A, 16'h4321);
    rdc("offset word", OFF_A, 16'h4321, 16'hffff);
    $display("test host registers done");
    for (int l = 0; l < 16; l++)
      for (int c = 0; c < 32; c++)
        hacc(1'b0, cm(4'(l), 8'(c)), {1'b0, FN_HIZ, 13'h0000});
    hacc(1'b0, cm(1, 3), {1'b0, FN_PROC, 5'h00, 8'ha5});
    hacc(1'b0, cm(2, 4), 16'h0507);
    rdc("connection word", cm(2, 4), 16'h0507, 16'hffff);
    chk("float all", 16'h0000, oe);
    pin = 1'b1;
    wait (tsw_serial_peer_i.frames >= 3);
    rdc("status", STAT_A, 16'h2000, 16'h3000);
    hacc(1'b0, dm(5, 7), 16'h0000);
    rdc("data memory", dm(5, 7), {8'h00, tsw_serial_peer_i.rx_byte(5, 7)}, 16'hffff);
    grab(1, 3);
    chk("processor byte", 16'h01a5, {7'h00, o, b});
    grab(2, 4);
    chk("switched byte", {8'h01, tsw_serial_peer_i.rx_byte(5, 7)}, {7'h00, o, b});
    grab(3, 5);
    chk("hiz channel", 16'h0000, {14'h0, o, di});
    $display("test serial paths done");
    pin = 1'b0;
    hacc(1'b0, CTRL_A, 16'h0f10);
    grab(1, 3);
    chk("standby drive", 16'h01a5, {7'h00, o, b});
    $display("test drive control done");
    wide = 1'b1;
    rdc("wide status", STAT_A, 16'h2000, 16'h3000);
    @(tsw_serial_peer_i.frames);
    grab(2, 4);
    chk("wide switched", {8'h01, tsw_serial_peer_i.rx_byte(5, 7)}, {7'h00, o, b});
    $display("test wide sync done");
    conclude();
  end
endmodule // tb_tsw_switch
`default_nettype wire
